// *** hw/sqsg_pkg.sv ***
// Shared constants for the switch QoS and snooping global control block
package sqsg_pkg;

    // ----------------------------------------------------------------
    // Bus and register map (register index, byte address = 4 * index)
    // ----------------------------------------------------------------
    localparam int          SQSG_ADDR_W         = 16;
    localparam int          SQSG_DATA_W         = 32;
    localparam logic [13:0] SQSG_IDX_MAP_FIRST  = 14'h0340;
    localparam logic [13:0] SQSG_IDX_MAP_TOP    = 14'h035F;
    localparam logic [13:0] SQSG_IDX_MIRROR     = 14'h0370;
    localparam logic [13:0] SQSG_IDX_WRED       = 14'h0378;
    localparam logic [13:0] SQSG_IDX_QMC0       = 14'h0390;
    localparam logic [1:0]  SQSG_RESP_OKAY      = 2'h0;
    localparam logic [1:0]  SQSG_RESP_DECERR    = 2'h3;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int          SQSG_MAP_HI_LSB     = 4;
    localparam int          SQSG_MAP_LO_LSB     = 0;
    localparam int          SQSG_BIT_IGMP_EN    = 6;
    localparam int          SQSG_BIT_MLD_OPT    = 3;
    localparam int          SQSG_BIT_MLD_EN     = 2;
    localparam int          SQSG_BIT_SNIFF_AND  = 0;
    localparam int          SQSG_WRED_RED_LSB   = 4;
    localparam int          SQSG_WRED_YEL_LSB   = 2;
    localparam int          SQSG_WRED_GRN_LSB   = 0;
    localparam int          SQSG_QMC_2Q_LSB     = 6;
    localparam int          SQSG_BIT_DISCARD    = 1;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [2:0]  SQSG_RST_PRIO       = 3'h0;
    localparam logic [1:0]  SQSG_RST_RED        = 2'h3;
    localparam logic [1:0]  SQSG_RST_YEL        = 2'h2;
    localparam logic [1:0]  SQSG_RST_GRN        = 2'h1;
    localparam logic        SQSG_RST_DISCARD    = 1'b1;

    // ----------------------------------------------------------------
    // IPv6 next-header codes used by listener-discovery snooping
    // ----------------------------------------------------------------
    localparam logic [7:0]  SQSG_NH_HOP_BY_HOP  = 8'h00;
    localparam logic [7:0]  SQSG_NH_ICMP        = 8'h01;
    localparam logic [7:0]  SQSG_NH_ICMPV6      = 8'h3A;
    localparam logic [7:0]  SQSG_NH_ROUTING     = 8'h2B;
    localparam logic [7:0]  SQSG_NH_FRAGMENT    = 8'h2C;
    localparam logic [7:0]  SQSG_NH_ESP         = 8'h32;
    localparam logic [7:0]  SQSG_NH_AUTH        = 8'h33;
    localparam logic [7:0]  SQSG_NH_DEST_OPT    = 8'h3C;

    // ----------------------------------------------------------------
    // Two-queue priority map encodings
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        SQSG_2Q_HIGH_3     = 2'h0,
        SQSG_2Q_UNUSED     = 2'h1,
        SQSG_2Q_HIGH_23    = 2'h2,
        SQSG_2Q_HIGH_123   = 2'h3
    } sqsg_two_q_t;

    localparam sqsg_two_q_t SQSG_RST_2Q         = SQSG_2Q_HIGH_23;

endpackage

// *** hw/sqsg_nh_match.sv ***
// IPv6 next-header classifier for listener-discovery snooping
`timescale 1ns/100ps

module sqsg_nh_match
    import sqsg_pkg::*;
(
    input  wire logic [7:0] i_next_hdr,
    input  wire logic       i_opt_ext,
    output logic            o_hit
);

    // Option picks extension-header set instead of ICMP/ICMPv6
    always_comb begin
        if (i_opt_ext) begin
            o_hit = (i_next_hdr == SQSG_NH_ROUTING) || (i_next_hdr == SQSG_NH_FRAGMENT) ||
                    (i_next_hdr == SQSG_NH_ESP) || (i_next_hdr == SQSG_NH_AUTH) ||
                    (i_next_hdr == SQSG_NH_DEST_OPT);
        end else begin
            o_hit = (i_next_hdr == SQSG_NH_ICMP) || (i_next_hdr == SQSG_NH_ICMPV6);
        end
    end

endmodule

// *** hw/sqsg_ctrl.sv ***
// Switch QoS, snooping and mirroring global control registers with AXI4-Lite slave
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps

module sqsg_ctrl
    import sqsg_pkg::*;
(
    input  wire logic                         i_clk,
    input  wire logic                         i_rst_n,
    // AXI4-Lite slave
    input  wire logic                         i_awvalid,
    output logic                              o_awready,
    input  wire logic [sqsg_pkg::SQSG_ADDR_W-1:0] i_awaddr,
    input  wire logic                         i_wvalid,
    output logic                              o_wready,
    input  wire logic [sqsg_pkg::SQSG_DATA_W-1:0] i_wdata,
    input  wire logic [3:0]                   i_wstrb,
    output logic                              o_bvalid,
    input  wire logic                         i_bready,
    output logic [1:0]                        o_bresp,
    input  wire logic                         i_arvalid,
    output logic                              o_arready,
    input  wire logic [sqsg_pkg::SQSG_ADDR_W-1:0] i_araddr,
    output logic                              o_rvalid,
    input  wire logic                         i_rready,
    output logic [sqsg_pkg::SQSG_DATA_W-1:0]  o_rdata,
    output logic [1:0]                        o_rresp,
    // Frame classification inputs
    input  wire logic [5:0]                   i_dscp,
    input  wire logic                         i_is_igmp,
    input  wire logic                         i_is_ipv6,
    input  wire logic [7:0]                   i_next_hdr,
    input  wire logic [7:0]                   i_hbh_next_hdr,
    input  wire logic                         i_mirror_enable,
    input  wire logic                         i_sniff_src_match,
    input  wire logic                         i_sniff_dst_match,
    input  wire logic                         i_two_queue_sel,
    input  wire logic [1:0]                   i_regen_prio,
    input  wire logic                         i_single_dest,
    // Decisions to the forwarding logic
    output logic [2:0]                        o_dscp_prio,
    output logic                              o_igmp_to_host,
    output logic                              o_mld_to_host,
    output logic                              o_mirror,
    output logic                              o_queue_high,
    output logic                              o_restrict_membership,
    output logic                              o_single_dest_drop,
    output logic [1:0]                        o_wred_red,
    output logic [1:0]                        o_wred_yellow,
    output logic [1:0]                        o_wred_green
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic                    aw_rdy;
        logic                    w_rdy;
        logic                    aw_got;
        logic                    w_got;
        logic [SQSG_ADDR_W-1:0]  waddr;
        logic [SQSG_DATA_W-1:0]  wdata;
        logic                    wstrb0;
        logic                    bvalid;
        logic [1:0]              bresp;
        logic                    ar_rdy;
        logic                    rvalid;
        logic [SQSG_DATA_W-1:0]  rdata;
        logic [1:0]              rresp;
        logic [31:0][5:0]        map;
        logic                    igmp_en;
        logic                    mld_opt;
        logic                    mld_en;
        logic                    sniff_and;
        logic [1:0]              red;
        logic [1:0]              yel;
        logic [1:0]              grn;
        sqsg_two_q_t             two_q;
        logic                    discard;
        logic [2:0]              dscp_prio;
        logic                    igmp_host;
        logic                    mld_host;
        logic                    mirror;
        logic                    q_high;
        logic                    restrict_mem;
        logic                    sd_drop;
    } sqsg_state_t;

    sqsg_state_t st_reg;
    sqsg_state_t st_next;
    logic [13:0] widx;
    logic [13:0] ridx;
    logic        nh_hit;
    logic        hbh_hit;
    logic        mld_match;
    logic        sniff_hit;
    logic [5:0]  top_map;

    // ----------------------------------------------------------------
    // Next-header classifiers
    // ----------------------------------------------------------------
    sqsg_nh_match u_nh_match (
        .i_next_hdr (i_next_hdr),
        .i_opt_ext  (st_reg.mld_opt),
        .o_hit      (nh_hit)
    );

    sqsg_nh_match u_hbh_match (
        .i_next_hdr (i_hbh_next_hdr),
        .i_opt_ext  (st_reg.mld_opt),
        .o_hit      (hbh_hit)
    );

    // Direct hit or hop-by-hop followed by a hit
    assign mld_match = nh_hit || ((i_next_hdr == SQSG_NH_HOP_BY_HOP) && hbh_hit);
    // Global mode alone never mirrors; per-port enable arrives on i_mirror_enable
    assign sniff_hit = i_mirror_enable && (st_reg.sniff_and ? (i_sniff_src_match && i_sniff_dst_match)
                                                            : (i_sniff_src_match || i_sniff_dst_match));
    assign top_map   = st_reg.map[31];

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        widx    = st_reg.waddr[SQSG_ADDR_W-1:2];
        ridx    = i_araddr[SQSG_ADDR_W-1:2];
        // Address and data are taken independently, in either order
        if (st_reg.aw_rdy && i_awvalid) begin
            st_next.aw_got = 1'b1;
            st_next.waddr  = i_awaddr;
        end
        if (st_reg.w_rdy && i_wvalid) begin
            st_next.w_got  = 1'b1;
            st_next.wdata  = i_wdata;
            st_next.wstrb0 = i_wstrb[0];
        end
        if (st_reg.bvalid && i_bready) begin
            st_next.bvalid = 1'b0;
        end
        // Commit once both halves are held; only byte lane 0 carries data
        if (st_reg.aw_got && st_reg.w_got && !st_reg.bvalid) begin
            st_next.aw_got = 1'b0;
            st_next.w_got  = 1'b0;
            st_next.bvalid = 1'b1;
            st_next.bresp  = SQSG_RESP_OKAY;
            if (widx >= SQSG_IDX_MAP_FIRST && widx <= SQSG_IDX_MAP_TOP) begin
                if (st_reg.wstrb0) begin
                    st_next.map[widx[4:0]] = {st_reg.wdata[SQSG_MAP_HI_LSB+:3],
                                              st_reg.wdata[SQSG_MAP_LO_LSB+:3]};
                end
            end else if (widx == SQSG_IDX_MIRROR) begin
                if (st_reg.wstrb0) begin
                    st_next.igmp_en   = st_reg.wdata[SQSG_BIT_IGMP_EN];
                    st_next.mld_opt   = st_reg.wdata[SQSG_BIT_MLD_OPT];
                    st_next.mld_en    = st_reg.wdata[SQSG_BIT_MLD_EN];
                    st_next.sniff_and = st_reg.wdata[SQSG_BIT_SNIFF_AND];
                end
            end else if (widx == SQSG_IDX_WRED) begin
                if (st_reg.wstrb0) begin
                    st_next.red = st_reg.wdata[SQSG_WRED_RED_LSB+:2];
                    st_next.yel = st_reg.wdata[SQSG_WRED_YEL_LSB+:2];
                    st_next.grn = st_reg.wdata[SQSG_WRED_GRN_LSB+:2];
                end
            end else if (widx == SQSG_IDX_QMC0) begin
                if (st_reg.wstrb0) begin
                    st_next.two_q   = sqsg_two_q_t'(st_reg.wdata[SQSG_QMC_2Q_LSB+:2]);
                    st_next.discard = st_reg.wdata[SQSG_BIT_DISCARD];
                end
            end else begin
                st_next.bresp = SQSG_RESP_DECERR;
            end
        end
        st_next.aw_rdy = !st_next.aw_got && !st_next.bvalid;
        st_next.w_rdy  = !st_next.w_got && !st_next.bvalid;
        // Read path: one outstanding read, reserved bits return zero
        if (st_reg.rvalid && i_rready) begin
            st_next.rvalid = 1'b0;
        end
        if (st_reg.ar_rdy && i_arvalid) begin
            st_next.rvalid = 1'b1;
            st_next.rresp  = SQSG_RESP_OKAY;
            st_next.rdata  = '0;
            if (ridx >= SQSG_IDX_MAP_FIRST && ridx <= SQSG_IDX_MAP_TOP) begin
                st_next.rdata[SQSG_MAP_HI_LSB+:3] = st_reg.map[ridx[4:0]][5:3];
                st_next.rdata[SQSG_MAP_LO_LSB+:3] = st_reg.map[ridx[4:0]][2:0];
            end else if (ridx == SQSG_IDX_MIRROR) begin
                st_next.rdata[SQSG_BIT_IGMP_EN]   = st_reg.igmp_en;
                st_next.rdata[SQSG_BIT_MLD_OPT]   = st_reg.mld_opt;
                st_next.rdata[SQSG_BIT_MLD_EN]    = st_reg.mld_en;
                st_next.rdata[SQSG_BIT_SNIFF_AND] = st_reg.sniff_and;
            end else if (ridx == SQSG_IDX_WRED) begin
                st_next.rdata[SQSG_WRED_RED_LSB+:2] = st_reg.red;
                st_next.rdata[SQSG_WRED_YEL_LSB+:2] = st_reg.yel;
                st_next.rdata[SQSG_WRED_GRN_LSB+:2] = st_reg.grn;
            end else if (ridx == SQSG_IDX_QMC0) begin
                st_next.rdata[SQSG_QMC_2Q_LSB+:2] = st_reg.two_q;
                st_next.rdata[SQSG_BIT_DISCARD]   = st_reg.discard;
            end else begin
                st_next.rresp = SQSG_RESP_DECERR;
            end
        end
        st_next.ar_rdy = !st_next.rvalid;

        // Forwarding decisions, one cycle after the frame inputs
        st_next.dscp_prio = i_dscp[0] ? st_reg.map[i_dscp[5:1]][5:3]
                                      : st_reg.map[i_dscp[5:1]][2:0];
        st_next.igmp_host = st_reg.igmp_en && i_is_igmp;
        st_next.mld_host  = st_reg.mld_en && i_is_ipv6 && mld_match;
        st_next.mirror    = sniff_hit;
        // Encoding 01 must not be programmed; it behaves like the reset map
        case (st_reg.two_q)
            SQSG_2Q_HIGH_3:   st_next.q_high = (i_regen_prio == 2'h3);
            SQSG_2Q_HIGH_23:  st_next.q_high = i_regen_prio[1];
            SQSG_2Q_HIGH_123: st_next.q_high = (i_regen_prio != 2'h0);
            default:          st_next.q_high = i_regen_prio[1];
        endcase
        if (!i_two_queue_sel) begin
            st_next.q_high = 1'b0;
        end
        st_next.restrict_mem = st_reg.discard || !i_single_dest;
        st_next.sd_drop      = !st_reg.discard && i_single_dest && sniff_hit;
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_reg         <= '0;
            st_reg.red     <= SQSG_RST_RED;
            st_reg.yel     <= SQSG_RST_YEL;
            st_reg.grn     <= SQSG_RST_GRN;
            st_reg.two_q   <= SQSG_RST_2Q;
            st_reg.discard <= SQSG_RST_DISCARD;
        end else begin
            st_reg <= st_next;
        end
    end

    // ----------------------------------------------------------------
    // Outputs, all straight from flops
    // ----------------------------------------------------------------
    assign o_awready             = st_reg.aw_rdy;
    assign o_wready              = st_reg.w_rdy;
    assign o_bvalid              = st_reg.bvalid;
    assign o_bresp               = st_reg.bresp;
    assign o_arready             = st_reg.ar_rdy;
    assign o_rvalid              = st_reg.rvalid;
    assign o_rdata               = st_reg.rdata;
    assign o_rresp               = st_reg.rresp;
    assign o_dscp_prio           = st_reg.dscp_prio;
    assign o_igmp_to_host        = st_reg.igmp_host;
    assign o_mld_to_host         = st_reg.mld_host;
    assign o_mirror              = st_reg.mirror;
    assign o_queue_high          = st_reg.q_high;
    assign o_restrict_membership = st_reg.restrict_mem;
    assign o_single_dest_drop    = st_reg.sd_drop;
    assign o_wred_red            = st_reg.red;
    assign o_wred_yellow         = st_reg.yel;
    assign o_wred_green          = st_reg.grn;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    sequence s_write_taken;
        i_awvalid && o_awready && i_wvalid && o_wready;
    endsequence

    sequence s_write_answer;
        ##[1:2] o_bvalid;
    endsequence

    AST_DSCP_ODD: assert property (i_dscp == 6'h3F |=> o_dscp_prio == $past(top_map[5:3]))
        else $error("DSCP 3F priority not from upper field");
    AST_DSCP_EVEN: assert property (i_dscp == 6'h3E |=> o_dscp_prio == $past(top_map[2:0]))
        else $error("DSCP 3E priority not from lower field");
    AST_IGMP: assert property (i_is_igmp |=> o_igmp_to_host == $past(st_reg.igmp_en))
        else $error("IGMP forwarding does not follow enable");
    AST_MLD_STD: assert property (st_reg.mld_en && !st_reg.mld_opt && i_is_ipv6 &&
                                  i_next_hdr == SQSG_NH_ICMPV6 |=> o_mld_to_host)
        else $error("ICMPv6 next header not snooped");
    AST_MLD_OPT: assert property (st_reg.mld_en && st_reg.mld_opt && i_is_ipv6 && i_next_hdr == 8'h00 &&
                                  i_hbh_next_hdr == SQSG_NH_DEST_OPT |=> o_mld_to_host)
        else $error("Hop-by-hop extension match not snooped");
    AST_SNIFF_AND: assert property (i_mirror_enable && st_reg.sniff_and && i_sniff_src_match &&
                                    !i_sniff_dst_match |=> !o_mirror)
        else $error("AND sniff mirrored on source only");
    AST_SNIFF_OR: assert property (i_mirror_enable && !st_reg.sniff_and && i_sniff_src_match |=> o_mirror)
        else $error("OR sniff missed a source match");
    AST_Q_MAP: assert property (i_two_queue_sel && i_regen_prio == 2'h1 |=>
                                o_queue_high == ($past(st_reg.two_q) == SQSG_2Q_HIGH_123))
        else $error("Priority 1 queue placement wrong");
    AST_Q_MAP_TOP: assert property (i_two_queue_sel && i_regen_prio == 2'h3 |=> o_queue_high)
        else $error("Priority 3 not in high queue");
    AST_DROP: assert property (i_single_dest && sniff_hit && !st_reg.discard |=>
                               o_single_dest_drop && !o_restrict_membership)
        else $error("Mirrored single-destination frame not dropped");
    AST_RESTRICT: assert property (st_reg.discard |=> o_restrict_membership && !o_single_dest_drop)
        else $error("Discard set did not restrict frame");
    AST_WRITE_RESP: assert property (s_write_taken |-> s_write_answer)
        else $error("Write response late");
    AST_RSV_ZERO: assert property (o_rvalid |-> o_rdata[31:8] == 24'h000000)
        else $error("Reserved read bits not zero");

endmodule

// *** testbench/sqsg_ctrl_tb_top.sv ***
// Self-checking bench for the QoS, snooping and mirroring global control block
`timescale 1ns/100ps
module sqsg_ctrl_tb_top;
    import sqsg_pkg::*;
    // ----------------------------------------------------------------
    // Stimulus, outputs and notes
    // ----------------------------------------------------------------
    logic        i_clk = 0, i_rst_n = 0, i_awvalid = 0, i_wvalid = 0, i_bready = 0, i_arvalid = 0, i_rready = 0;
    logic [15:0] i_awaddr = '0, i_araddr = '0;
    logic [31:0] i_wdata = '0, o_rdata;
    logic [3:0]  i_wstrb = '0;
    logic [5:0]  i_dscp = '0;
    logic [7:0]  i_next_hdr = '0, i_hbh_next_hdr = '0;
    logic [1:0]  i_regen_prio = '0, o_bresp, o_rresp, o_wred_red, o_wred_yellow, o_wred_green;
    logic        i_is_igmp = 0, i_is_ipv6 = 0, i_mirror_enable = 0, i_sniff_src_match = 0;
    logic        i_sniff_dst_match = 0, i_two_queue_sel = 0, i_single_dest = 0, dec_due = 0;
    logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_igmp_to_host, o_mld_to_host, o_mirror;
    logic        o_queue_high, o_restrict_membership, o_single_dest_drop;
    logic [2:0]  o_dscp_prio;
    logic [7:0]  map_sh [32];
    logic [7:0]  mir_sh, wred_sh, qmc_sh;
    logic [13:0] idx_tab [5] = '{SQSG_IDX_MAP_TOP, SQSG_IDX_MIRROR, SQSG_IDX_WRED, SQSG_IDX_QMC0, SQSG_IDX_MAP_FIRST};
    logic [7:0]  nh_tab [9] = '{8'h00, 8'h01, 8'h3A, 8'h2B, 8'h2C, 8'h32, 8'h33, 8'h3C, 8'h07};
    logic [1:0]  bq [$];
    logic [33:0] rq [$];
    logic [14:0] dq [$];
    int          n_fail = 0, num_checks = 0, cycles = 0;

    sqsg_ctrl i_dut (.*);

    // 40 ns period
    initial forever #20 i_clk = ~i_clk;

    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic fail(input string m);
        n_fail++;
        $display("MISMATCH t=%0t %s", $time, m);
    endtask
    task automatic chk_b(input logic [1:0] e, input logic [1:0] a);
        num_checks++;
        if (a !== e) fail($sformatf("bresp %h expected %h", a, e));
    endtask
    task automatic chk_rd(input logic [33:0] e, input logic [33:0] a);
        num_checks++;
        if (a !== e) fail($sformatf("read %h expected %h", a, e));
    endtask
    task automatic chk_dec(input logic [14:0] e, input logic [14:0] a);
        num_checks++;
        if (a !== e) fail($sformatf("decision %h expected %h", a, e));
    endtask
    // ----------------------------------------------------------------
    // Bus master: each half released when taken, response awaited
    // ----------------------------------------------------------------
    task automatic axw(input logic [13:0] idx, input logic [31:0] d, input logic [3:0] s, input logic [1:0] r);
        bq.push_back(r);
        @(posedge i_clk);
        {i_awvalid, i_wvalid, i_bready} <= 3'h7;
        {i_awaddr, i_wdata, i_wstrb} <= {idx, 2'h0, d, s};
        do begin
            @(posedge i_clk);
            if (i_awvalid && o_awready) i_awvalid <= 1'b0;
            if (i_wvalid && o_wready) i_wvalid <= 1'b0;
        end while (!(o_bvalid && i_bready));
        i_bready <= 1'b0;
    endtask
    task automatic axr(input logic [13:0] idx, input logic [33:0] e);
        rq.push_back(e);
        @(posedge i_clk);
        {i_arvalid, i_rready, i_araddr} <= {2'h3, idx, 2'h0};
        do begin
            @(posedge i_clk);
            if (i_arvalid && o_arready) i_arvalid <= 1'b0;
        end while (!(o_rvalid && i_rready));
        i_rready <= 1'b0;
    endtask
    // Reserved bits are masked off the shadow copy on every write
    task automatic wr_reg(input logic [13:0] idx, input logic [7:0] d);
        axw(idx, {24'hFFFFFF, d}, 4'hF, SQSG_RESP_OKAY);
        if (idx == SQSG_IDX_MIRROR) mir_sh = d & 8'h4D;
        else if (idx == SQSG_IDX_WRED) wred_sh = d & 8'h3F;
        else if (idx == SQSG_IDX_QMC0) qmc_sh = d & 8'hC2;
        else map_sh[idx[4:0]] = d & 8'h77;
    endtask
    task automatic rd_reg(input logic [13:0] idx);
        logic [7:0] v;
        v = idx == SQSG_IDX_MIRROR ? mir_sh : idx == SQSG_IDX_WRED ? wred_sh
          : idx == SQSG_IDX_QMC0 ? qmc_sh : map_sh[idx[4:0]];
        axr(idx, {SQSG_RESP_OKAY, 24'h0, v});
    endtask
    // ----------------------------------------------------------------
    // Reference decisions worked out from the register shadows
    // ----------------------------------------------------------------
    function automatic logic hdr_hit(input logic [7:0] h);
        return mir_sh[3] ? (h inside {8'h2B, 8'h2C, 8'h32, 8'h33, 8'h3C})
                         : (h inside {8'h01, 8'h3A});
    endfunction
    function automatic logic [14:0] exp_dec();
        logic [7:0] m;
        logic       mr, qh, dis;
        m = map_sh[i_dscp[5:1]];
        mr = i_mirror_enable & (mir_sh[0] ? i_sniff_src_match & i_sniff_dst_match
                                          : i_sniff_src_match | i_sniff_dst_match);
        qh = qmc_sh[7:6] == 2'h0 ? i_regen_prio == 2'h3 : qmc_sh[7:6] == 2'h3 ? i_regen_prio != 2'h0 : i_regen_prio[1];
        dis = qmc_sh[1];
        return {i_dscp[0] ? m[6:4] : m[2:0], mir_sh[6] & i_is_igmp,
                i_is_ipv6 & mir_sh[2] & (hdr_hit(i_next_hdr) | (i_next_hdr == 8'h00 & hdr_hit(i_hbh_next_hdr))),
                mr, i_two_queue_sel & qh, dis | ~i_single_dest, ~dis & i_single_dest & mr, wred_sh[5:0]};
    endfunction
    // Random frame held for two edges; decision noted when sampled
    task automatic frame(input logic mh = 1'b0);
        @(posedge i_clk);
        i_dscp <= $urandom_range(1) ? {5'h1F, 1'($urandom)} : 6'($urandom);
        // Per-port mirror enable stands in for software's per-port setting; mh forces IPv6 hop-by-hop
        {i_is_igmp, i_is_ipv6, i_mirror_enable, i_sniff_src_match, i_sniff_dst_match} <=
            5'($urandom) | {1'b0, mh, 3'h0};
        {i_two_queue_sel, i_single_dest, i_regen_prio} <= 4'($urandom);
        i_next_hdr <= mh ? 8'h00 : nh_tab[$urandom_range(8)];
        i_hbh_next_hdr <= mh ? 8'h3C : nh_tab[$urandom_range(8)];
        @(posedge i_clk);
        dq.push_back(exp_dec());
        dec_due <= 1'b1;
        @(posedge i_clk);
        dec_due <= 1'b0;
    endtask

    // Monitor: oldest note against each result as it appears; hang guard
    always @(posedge i_clk) begin
        if (o_bvalid && i_bready) chk_b(bq.pop_front(), o_bresp);
        if (o_rvalid && i_rready) chk_rd(rq.pop_front(), {o_rresp, o_rdata});
        if (dec_due) chk_dec(dq.pop_front(), {o_dscp_prio, o_igmp_to_host, o_mld_to_host, o_mirror, o_queue_high,
            o_restrict_membership, o_single_dest_drop, o_wred_red, o_wred_yellow, o_wred_green});
        cycles++;
        if (cycles > 20000) begin
            n_fail++;
            final_report();
        end
    end

    initial begin
        logic [13:0] idx;
        void'($urandom(63278));
        {mir_sh, wred_sh, qmc_sh} = {8'h00, 8'h39, 8'h82};
        foreach (map_sh[k]) map_sh[k] = 8'h00;
        repeat (2) @(posedge i_clk);
        i_rst_n <= 1'b1;
        foreach (idx_tab[k]) rd_reg(idx_tab[k]);
        frame();
        foreach (idx_tab[k]) wr_reg(idx_tab[k], 8'hFF);
        foreach (idx_tab[k]) rd_reg(idx_tab[k]);
        axw(SQSG_IDX_WRED, 32'h0, 4'h0, SQSG_RESP_OKAY);
        rd_reg(SQSG_IDX_WRED);
        axw(14'h0001, 32'hFF, 4'hF, SQSG_RESP_DECERR);
        axr(14'h0001, {SQSG_RESP_DECERR, 32'h0});
        // Random frames rarely hit the hop-by-hop extension case, so drive it once
        wr_reg(SQSG_IDX_MIRROR, 8'h4C);
        frame(1'b1);
        repeat (300) begin
            idx = $urandom_range(4) == 0 ? SQSG_IDX_MAP_FIRST + 14'($urandom_range(31)) : idx_tab[$urandom_range(3)];
            wr_reg(idx, 8'($urandom));
            rd_reg(idx);
            repeat (2) frame();
        end
        final_report();
    end
endmodule
